// >>> rtl/ufb_usart.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
module ufb_usart (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic sync_clock_pin,
  output logic sync_clock_oe,
  output logic tx_busy
);
  ufb_pkg::ufb_frame_t frame_ff;
  logic [11:0] baud_divisor_ff;
  logic dbl_ff;
  logic txen_ff;
  logic rxen_ff;
  logic size2_ff;
  logic tx9_ff;
  logic [7:0] rdata_ff;
  logic tx_on_ff;
  logic [11:0] pre_ff;
  logic [4:0] ovs_ff;
  logic tick_ff;
  logic half_ff;
  logic [3:0] nbits;
  logic [4:0] ovs_top;
  logic sync_mode;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  ufb_pkg::ufb_word_t fifo_out;
  ufb_pkg::ufb_word_t fifo_in;
  logic [11:0] shreg_ff;
  logic [3:0] tx_left_ff;
  logic tx_act_ff;
  logic txd_ff;
  logic xck_ff;
  logic sync_oe_ff;
  logic [9:0] rx_sh_ff;
  logic [3:0] rx_cnt_ff;
  logic rx_act_ff;
  logic rx_in_ff;
  logic [8:0] rx_data_ff;
  logic rx_par_err_ff;
  logic rx9_ff;
  logic [9:0] rx_word;
  function automatic logic [3:0] size_bits(input logic hi, input logic [1:0] lo);
    size_bits = hi ? 4'h9 : 4'(5 + lo);
  endfunction : size_bits
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
    begin
      if (i < n)
      begin
        p = p ^ d[i];
      end
    end
    par_of = p;
  endfunction : par_of
  assign nbits = size_bits(size2_ff, frame_ff.size_lo);
  assign sync_mode = (frame_ff.mode == ufb_pkg::MODE_SYNC);
  assign ovs_top = (dbl_ff && !sync_mode) ? ufb_pkg::OVS_DOUBLE : ufb_pkg::OVS_NORMAL;
  assign fifo_in = '{data: {tx9_ff, wdata}};
  // Gated by the drained-off state, not the enable, so queued words still go out
  assign fifo_pop = fifo_out_valid && !tx_act_ff && tick_ff && tx_on_ff;
  // Register writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_ff <= ufb_pkg::FRAME_RESET;
      baud_divisor_ff <= ufb_pkg::BAUD_RESET;
      dbl_ff <= 1'b0;
      txen_ff <= 1'b0;
      rxen_ff <= 1'b0;
      size2_ff <= 1'b0;
      tx9_ff <= 1'b0;
    end
    else if (wr)
    begin
      unique case (addr)
        ufb_pkg::ADDR_CTRL_A: dbl_ff <= wdata[ufb_pkg::A_DBL];
        ufb_pkg::ADDR_CTRL_B:
        begin
          rxen_ff <= wdata[ufb_pkg::B_RXEN];
          txen_ff <= wdata[ufb_pkg::B_TXEN];
          size2_ff <= wdata[ufb_pkg::B_SIZE2];
          tx9_ff <= wdata[ufb_pkg::B_TX9];
        end
        ufb_pkg::ADDR_FRAME: frame_ff <= wdata;
        ufb_pkg::ADDR_BAUD_LO: baud_divisor_ff[7:0] <= wdata;
        ufb_pkg::ADDR_BAUD_HI: baud_divisor_ff[11:8] <= wdata[3:0];
        default:
        begin
        end
      endcase
    end
  end
  // Reads; a data register read leaves receive state untouched
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
    end
    else if (rd)
    begin
      unique case (addr)
        ufb_pkg::ADDR_DATA: rdata_ff <= rx_data_ff[7:0];
        ufb_pkg::ADDR_CTRL_A: rdata_ff <= {5'h00, rx_par_err_ff, dbl_ff, 1'b0};
        ufb_pkg::ADDR_CTRL_B: rdata_ff <= {3'h0, rxen_ff, txen_ff, size2_ff, rx9_ff, tx9_ff};
        ufb_pkg::ADDR_FRAME: rdata_ff <= frame_ff;
        ufb_pkg::ADDR_BAUD_LO: rdata_ff <= baud_divisor_ff[7:0];
        ufb_pkg::ADDR_BAUD_HI: rdata_ff <= {4'h0, baud_divisor_ff[11:8]};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_ff;
  // Prescaler; tick is one bit period, half marks mid-bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_ff <= 12'h000;
      ovs_ff <= 5'h00;
      tick_ff <= 1'b0;
      half_ff <= 1'b0;
    end
    else if (wr && addr == ufb_pkg::ADDR_BAUD_LO)
    begin
      pre_ff <= {baud_divisor_ff[11:8], wdata};
      ovs_ff <= 5'h00;
      tick_ff <= 1'b0;
      half_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= 1'b0;
      half_ff <= 1'b0;
      if (pre_ff == 12'h000)
      begin
        pre_ff <= baud_divisor_ff;
        // Greater-or-equal so a drop from 16 to 8 steps never wraps the count
        if (ovs_ff >= ovs_top - 5'h01)
        begin
          ovs_ff <= 5'h00;
          tick_ff <= 1'b1;
        end
        else
        begin
          ovs_ff <= ovs_ff + 5'h01;
          half_ff <= (ovs_ff == (ovs_top >> 1) - 5'h01);
        end
      end
      else
      begin
        pre_ff <= pre_ff - 12'h001;
      end
    end
  end
  // Transmit buffer; the FIFO drops data register writes when full
  ufb_fifo #(
    .WIDTH(ufb_pkg::DATA_W),
    .DEPTH(ufb_pkg::FIFO_DEPTH)
  ) u_txfifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr && addr == ufb_pkg::ADDR_DATA),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  // Transmitter: frame = start, data, parity, stop(s), LSB first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shreg_ff <= 12'hFFF;
      tx_left_ff <= 4'h0;
      tx_act_ff <= 1'b0;
      txd_ff <= 1'b1;
      tx_on_ff <= 1'b0;
    end
    else
    begin
      if (txen_ff)
      begin
        tx_on_ff <= 1'b1;
      end
      else if (!tx_act_ff && !fifo_out_valid)
      begin
        tx_on_ff <= 1'b0;
      end
      if (fifo_pop)
      begin
        tx_act_ff <= 1'b1;
        txd_ff <= 1'b0;
        shreg_ff <= '1;
        for (int i = 0; i < 9; i++)
        begin
          if (i < nbits)
          begin
            shreg_ff[i] <= fifo_out.data[i];
          end
        end
        if (frame_ff.parity[1])
        begin
          shreg_ff[nbits] <= par_of(fifo_out.data, nbits, frame_ff.parity[0]);
        end
        tx_left_ff <= nbits + 4'(frame_ff.parity[1]) + 4'(frame_ff.two_stop) + 4'h1;
      end
      else if (tx_act_ff && tick_ff)
      begin
        if (tx_left_ff == 4'h0)
        begin
          tx_act_ff <= 1'b0;
          txd_ff <= 1'b1;
        end
        else
        begin
          txd_ff <= shreg_ff[0];
          shreg_ff <= {1'b1, shreg_ff[11:1]};
          tx_left_ff <= tx_left_ff - 4'h1;
        end
      end
    end
  end
  assign serial_out_pin = txd_ff;
  assign serial_out_oe = tx_on_ff;
  assign tx_busy = tx_act_ff;
  // Sync clock: data changes at tick, sampled at half
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xck_ff <= 1'b0;
      sync_oe_ff <= 1'b0;
    end
    else
    begin
      sync_oe_ff <= sync_mode && tx_on_ff;
      // Idles at the polarity level, so the first edge is always the data edge
      if (!sync_mode)
      begin
        xck_ff <= frame_ff.polarity;
      end
      else if (tick_ff)
      begin
        xck_ff <= !frame_ff.polarity;
      end
      else if (half_ff)
      begin
        xck_ff <= frame_ff.polarity;
      end
    end
  end
  assign sync_clock_pin = xck_ff;
  assign sync_clock_oe = sync_oe_ff;
  // Frame aligned so data sits at bit 0 and parity right above it
  assign rx_word = rx_sh_ff >> (4'hA - nbits - 4'(frame_ff.parity[1]));
  // Receiver: sample mid-bit on half; stop setting ignored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_in_ff <= 1'b1;
      rx_sh_ff <= 10'h000;
      rx_cnt_ff <= 4'h0;
      rx_act_ff <= 1'b0;
      rx_data_ff <= 9'h000;
      rx9_ff <= 1'b0;
      rx_par_err_ff <= 1'b0;
    end
    else
    begin
      rx_in_ff <= serial_in_pin;
      if (!rxen_ff)
      begin
        rx_act_ff <= 1'b0;
      end
      else if (!rx_act_ff && !rx_in_ff && half_ff)
      begin
        rx_act_ff <= 1'b1;
        rx_cnt_ff <= nbits + 4'(frame_ff.parity[1]);
      end
      else if (rx_act_ff && half_ff)
      begin
        if (rx_cnt_ff == 4'h0)
        begin
          rx_act_ff <= 1'b0;
          rx_data_ff <= rx_word[8:0] & (9'h1FF >> (4'h9 - nbits));
          rx9_ff <= (nbits == 4'h9) && rx_word[8];
          rx_par_err_ff <= frame_ff.parity[1] &&
            (par_of(rx_word[8:0], nbits, frame_ff.parity[0]) != rx_word[nbits]);
        end
        else
        begin
          rx_sh_ff <= {rx_in_ff, rx_sh_ff[9:1]};
          rx_cnt_ff <= rx_cnt_ff - 4'h1;
        end
      end
    end
  end
  txoff_after_drain_a: assert property (@(posedge clk) disable iff (rst)
    (!txen_ff && (tx_act_ff || fifo_out_valid)) |=> tx_on_ff || !$past(tx_on_ff))
    else $error("Transmitter turned off with data pending");
  pin_release_a: assert property (@(posedge clk) disable iff (rst)
    !tx_on_ff |-> !serial_out_oe)
    else $error("Serial output still driven while off");
  hi_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == ufb_pkg::ADDR_BAUD_HI) |=> rdata[7:4] == 4'h0)
    else $error("Upper divisor bits not zero");
  reload_now_a: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == ufb_pkg::ADDR_BAUD_LO) |=> pre_ff == {baud_divisor_ff[11:8], $past(wdata)})
    else $error("Prescaler not reloaded");
  tick_rate_a: assert property (@(posedge clk) disable iff (rst)
    tick_ff |-> ##1 !tick_ff [*7])
    else $error("Bit tick too frequent");
  stop_count_a: assert property (@(posedge clk) disable iff (rst)
    fifo_pop |=> tx_left_ff == nbits + 4'(frame_ff.parity[1]) + 4'(frame_ff.two_stop) + 4'h1)
    else $error("Wrong frame length");
  size_code_a: assert property (@(posedge clk) disable iff (rst)
    size2_ff |-> nbits == 4'h9)
    else $error("Wrong character size");
  sync_clk_oe_a: assert property (@(posedge clk) disable iff (rst)
    !sync_mode |=> !sync_clock_oe)
    else $error("Sync clock driven outside sync mode");
  xck_data_edge_a: assert property (@(posedge clk) disable iff (rst)
    (sync_mode && tick_ff) |=> sync_clock_pin != $past(frame_ff.polarity))
    else $error("Sync clock data edge has wrong direction");
  xck_sample_edge_a: assert property (@(posedge clk) disable iff (rst)
    (sync_mode && half_ff) |=> sync_clock_pin == $past(frame_ff.polarity))
    else $error("Sync clock sample edge has wrong direction");
  drain_hold_a: assert property (@(posedge clk) disable iff (rst)
    (tx_on_ff && (tx_act_ff || fifo_out_valid)) |=> tx_on_ff)
    else $error("Transmitter dropped with data pending");
  idle_high_a: assert property (@(posedge clk) disable iff (rst)
    !tx_on_ff |-> serial_out_pin)
    else $error("Serial output not idle while released");
endmodule : ufb_usart

// >>> shared/ufb_pkg.sv
// Contract
// - Clearing transmit enable waits until shift register and buffer are empty.
// - Once the transmitter is off it releases the serial output pin.
// - Mode field: 00 async, 01 sync, 10 reserved, 11 master SPI; the code has no SPI logic and runs 11 as async.
// - With parity on, transmitter computes and inserts frame parity.
// - With parity on, receiver checks parity and sets the error flag.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// - Stop select gives one or two transmitted stop bits; receiver ignores it.
// - Size code 000..011 gives 5..8 bits, 111 gives 9, others reserved; the code also gives 9 for 100..110.
// - Sync polarity 0: transmit on rising, sample on falling; 1 swaps.
// - Baud divisor is 12 bits: four high bits, eight low bits.
// - Writing the low divisor register reloads the prescaler at once.
// - Double speed in async mode cuts the per-bit divisor from 16 to 8.
package ufb_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_CTRL_A = 3'h1;
  localparam logic [2:0] ADDR_CTRL_B = 3'h2;
  localparam logic [2:0] ADDR_FRAME = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
  localparam logic [7:0] FRAME_RESET = 8'h06;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam int A_PAR_ERR = 2;
  localparam int A_DBL = 1;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_SIZE2 = 2;
  localparam int B_RX9 = 1;
  localparam int B_TX9 = 0;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 9;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  typedef enum logic [1:0] {MODE_ASYNC = 2'h0, MODE_SYNC = 2'h1, MODE_RSVD = 2'h2, MODE_SPI = 2'h3} ufb_mode_t;
  typedef struct packed {
    ufb_mode_t mode;
    logic [1:0] parity;
    logic two_stop;
    logic [1:0] size_lo;
    logic polarity;
  } ufb_frame_t;
  typedef struct packed {
    logic [DATA_W-1:0] data;
  } ufb_word_t;
endpackage : ufb_pkg

// >>> rtl/ufb_fifo.sv
`timescale 1ns/100ps
module ufb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ufb_fifo

// >>> test/ufb_peer.sv
`timescale 1ns/100ps
module ufb_peer (
  input wire logic clk,
  input wire logic line_in,
  input wire logic [15:0] bit_clks,
  input wire logic [4:0] nbits,
  output logic line_out,
  output logic [15:0] cap,
  output int got
);
  initial line_out = 1'b1;
  initial got = 0;
  initial cap = '0;
  // Samples each bit at its middle, start bit first; no wait after the last one
  always
  begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk);
    cap = '0;
    cap[0] = line_in;
    for (int i = 1; i < nbits; i++)
    begin
      repeat (bit_clks) @(posedge clk);
      cap[i] = line_in;
    end
    got = got + 1;
  end
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : send
endmodule : ufb_peer

// >>> test/test_ufb_usart.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("Error %0t got %h exp %h", $time, a, e); end end
module test_ufb_usart;
  logic clk, rst, wr, rd, tx_busy, out_pin, out_oe, in_pin, sclk, soe;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] bclk;
  logic [4:0] nb;
  int errors = 0;
  int checks = 0;
  logic [7:0] fr_t [6] = '{8'h06, 8'h00, 8'h22, 8'h34, 8'h2E, 8'h3E};
  logic s2_t [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [8:0] d_t [6] = '{9'h05A, 9'h015, 9'h022, 9'h055, 9'h0F0, 9'h1A5};
  // Released output floats to the line pull-up
  wire line = out_oe ? out_pin : 1'b1;
  ufb_usart uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_in_pin(in_pin), .serial_out_pin(out_pin), .serial_out_oe(out_oe), .sync_clock_pin(sclk),
    .sync_clock_oe(soe), .tx_busy(tx_busy));
  ufb_peer peer (.clk(clk), .line_in(line), .bit_clks(bclk), .nbits(nb), .line_out(in_pin), .cap(), .got());
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata & m;
    `CHK(d, e)
  endtask : chk_reg
  // Start, data LSB first, parity, stop bits
  function automatic logic [15:0] fbits(input logic [7:0] fr, input logic s2, input logic [8:0] d, output int n);
    int sz;
    fbits = '0;
    sz = s2 ? 9 : int'(fr[2:1]) + 5;
    for (int i = 0; i < sz; i++)
      fbits[1 + i] = d[i];
    n = 1 + sz;
    if (fr[5])
    begin
      fbits[n] = fr[4] ^ (^(d & ((9'h1 << sz) - 9'h1)));
      n++;
    end
    for (int i = 0; i <= int'(fr[3]); i++)
    begin
      fbits[n] = 1'b1;
      n++;
    end
  endfunction : fbits
  // Two words; the second must still go out when enable is cleared behind them
  task automatic tx(input logic [7:0] fr, input logic s2, input logic [8:0] d, input logic off);
    logic [15:0] e;
    int n;
    int g;
    e = fbits(fr, s2, d, n);
    nb = 5'(n);
    g = peer.got;
    wr_reg(ufb_pkg::ADDR_FRAME, fr);
    wr_reg(ufb_pkg::ADDR_CTRL_B, {3'h0, 1'b1, 1'b1, s2, 1'b0, d[8]});
    wr_reg(ufb_pkg::ADDR_DATA, d[7:0]);
    wr_reg(ufb_pkg::ADDR_DATA, d[7:0]);
    if (off)
      wr_reg(ufb_pkg::ADDR_CTRL_B, {3'h0, 1'b1, 1'b0, s2, 1'b0, d[8]});
    `CHK(out_oe, 1'b1)
    for (int i = 0; i < 4000 && peer.got == g; i++)
      @(posedge clk);
    `CHK(peer.cap & ((16'h1 << nb) - 16'h1), e)
    for (int i = 0; i < 9000 && tx_busy !== 1'b0; i++)
      @(posedge clk);
    repeat (16 * bclk) @(posedge clk);
    `CHK(out_oe, !off)
    `CHK(peer.got, g + 2)
    `CHK(peer.cap & ((16'h1 << nb) - 16'h1), e)
  endtask : tx
  // Sync mode: data edge at the start bit, opposite edge mid-bit
  task automatic sync_tx(input logic p);
    wr_reg(ufb_pkg::ADDR_FRAME, {2'b01, 5'h03, p});
    wr_reg(ufb_pkg::ADDR_CTRL_B, 8'h08);
    wr_reg(ufb_pkg::ADDR_DATA, 8'h00);
    for (int i = 0; i < 2000 && out_pin !== 1'b0; i++)
      @(negedge clk);
    `CHK(sclk, !p)
    `CHK(soe, 1'b1)
    repeat (20) @(negedge clk);
    `CHK(sclk, p)
    for (int i = 0; i < 2000 && tx_busy !== 1'b0; i++)
      @(posedge clk);
  endtask : sync_tx
  // Receiver takes one stop bit whatever the stop select says
  task automatic rx(input logic [7:0] fr, input logic s2, input logic [8:0] d, input logic bad);
    logic [15:0] e;
    int n;
    e = fbits(fr & 8'hF7, s2, d, n);
    if (bad)
      e[n - 2] = ~e[n - 2];
    wr_reg(ufb_pkg::ADDR_FRAME, fr);
    wr_reg(ufb_pkg::ADDR_CTRL_B, {3'h0, 1'b1, 1'b0, s2, 2'h0});
    peer.send(e, n);
    repeat (2 * bclk) @(posedge clk);
    chk_reg(ufb_pkg::ADDR_CTRL_A, 8'h04, {5'h0, bad, 2'h0});
    chk_reg(ufb_pkg::ADDR_CTRL_B, 8'h02, {6'h0, d[8], 1'b0});
    chk_reg(ufb_pkg::ADDR_DATA, 8'hFF, d[7:0]);
  endtask : rx
  task automatic results;
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bclk = 16'd32;
    nb = 5'd1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk_reg(ufb_pkg::ADDR_FRAME, 8'hFF, ufb_pkg::FRAME_RESET);
    chk_reg(ufb_pkg::ADDR_BAUD_LO, 8'hFF, 8'h00);
    chk_reg(ufb_pkg::ADDR_BAUD_HI, 8'hFF, 8'h00);
    chk_reg(3'h6, 8'hFF, 8'h00);
    wr_reg(ufb_pkg::ADDR_BAUD_HI, 8'hF5);
    chk_reg(ufb_pkg::ADDR_BAUD_HI, 8'hFF, 8'h05);
    wr_reg(ufb_pkg::ADDR_BAUD_HI, 8'h00);
    wr_reg(ufb_pkg::ADDR_BAUD_LO, 8'h01);
    chk_reg(ufb_pkg::ADDR_BAUD_LO, 8'hFF, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(ufb_pkg::ADDR_FRAME, {m[1:0], 6'h06});
      chk_reg(ufb_pkg::ADDR_FRAME, 8'hFF, {m[1:0], 6'h06});
    end
    // Divisor 1 gives 32 clocks a bit, 16 at double speed
    for (int k = 0; k < 2; k++)
    begin
      bclk = k ? 16'd16 : 16'd32;
      wr_reg(ufb_pkg::ADDR_CTRL_A, k ? 8'h02 : 8'h00);
      for (int i = 0; i < 6; i++)
        tx(fr_t[i], s2_t[i], d_t[i], i == 5);
    end
    sync_tx(1'b0);
    sync_tx(1'b1);
    rx(8'h2E, 1'b0, 9'h0C3, 1'b0);
    rx(8'h2E, 1'b0, 9'h0C3, 1'b1);
    rx(8'h06, 1'b1, 9'h155, 1'b0);
    results();
  end
endmodule : test_ufb_usart
